// ==== rpsp_pkg.sv ====
`default_nettype none
package rpsp_pkg;
    // register offsets
    localparam logic [7:0] ADDR_INT_STATUS = 8'h13;
    localparam logic [7:0] ADDR_STATE_CTRL = 8'h14;
    localparam logic [7:0] ADDR_DET_TIME = 8'h17;
    localparam logic [7:0] ADDR_WAIT_RATIO = 8'h18;
    // digital receive configuration window, reached over the same port
    localparam logic [7:0] ADDR_RXCFG_FIRST = 8'h00;
    localparam int RXCFG_WORDS = 16;
    // field positions
    localparam int CTRL_XO_BIT = 0;
    localparam int CTRL_WUT_BIT = 1;
    localparam int CTRL_HRX_BIT = 2;
    localparam int STAT_PREAMB_BIT = 0;
    localparam int RATIO_WIDTH = 7;
    // reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] DET_TIME_RESET = 8'h00;
    localparam logic [7:0] WAIT_RATIO_RESET = 8'h00;
    // timing, clock period in ns
    localparam int CLK_PERIOD_NS = 5;
    localparam int T_SHUTDOWN_NS = 10000;
    localparam int T_TURN_ON_NS = 400000;
    localparam int T_XO_START_NS = 380000;
    localparam int T_RX_START_NS = 320000;
    localparam int T_FAST_NS = 10000;
    localparam int T_DET_BASE_NS = 480000;
    localparam int T_DET_STEP_NS = 80000;
    // longest times round down, least times round up
    localparam int SHUTDOWN_CYC = T_SHUTDOWN_NS / CLK_PERIOD_NS;
    localparam int TURN_ON_CYC = (T_TURN_ON_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int XO_START_CYC = (T_XO_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RX_START_CYC = (T_RX_START_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAST_CYC = T_FAST_NS / CLK_PERIOD_NS;
    localparam int DET_BASE_CYC = T_DET_BASE_NS / CLK_PERIOD_NS;
    localparam int DET_STEP_CYC = T_DET_STEP_NS / CLK_PERIOD_NS;

    // nine states need a four-bit code
    typedef enum logic [3:0] {
        ST_SHUTDOWN, ST_POWERUP, ST_SLEEP, ST_XO_START, ST_STANDBY,
        ST_RX_START, ST_HOST_RX, ST_POLL_RX, ST_WAIT
    } rpsp_state_type;

    // one serial register access, already deserialised
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } rpsp_req_type;

    // decoded power-state control bits
    typedef struct packed {
        logic host_rx_enable;
        logic wake_timer_enable;
        logic crystal_enable;
    } rpsp_ctrl_type;
endpackage
`default_nettype wire

// ==== rpsp_cfg_mem.sv ====
`default_nettype none
// small register memory for the receive configuration words
module rpsp_cfg_mem #(
    parameter int WORDS = 16,
    parameter int AW = 4
) (
    // clocking
    input wire logic clock_i,
    input wire logic clk_en_i,
    input wire logic sys_rst_i,
    // access
    input wire logic wr_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_q [WORDS];

    // reset clears every word so defaults return after power-up
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < WORDS; i++) begin
                mem_q[i] <= 8'h00;
            end
            rdata_o <= 8'h00;
        end else if (clk_en_i) begin
            if (wr_i) begin
                mem_q[addr_i] <= wdata_i;
            end
            rdata_o <= mem_q[addr_i];
        end
    end
endmodule // rpsp_cfg_mem
`default_nettype wire

// ==== rpsp_power_ctrl.sv ====
// Functional notes
// - power-down high: shutdown within 10 us
// - power-down low: sleep, registers defaulted
// - crystal enable in sleep: standby, 380 us
// - rx off, xo off, wake timer: 10 us
// - host receive enable: receiver on in 320 us
// - receive config read-only while receiving
// - control register writable in host receive
// - wake timer alternates wait and polling
// - detection time field, 0.48 to 20.88 ms
// - wait equals detection times ratio; the code uses detection times (ratio field plus one)
// - preamble sets flag, data falls later
// - status read clears flag, timer, to standby
// - data high in polling and idle wait
// - unread status repeats falling edge each cycle
`default_nettype none
module rpsp_power_ctrl
    import rpsp_pkg::*;
#(
    parameter int SHUTDOWN_CYCLES = SHUTDOWN_CYC,
    parameter int TURN_ON_CYCLES = TURN_ON_CYC,
    parameter int XO_START_CYCLES = XO_START_CYC,
    parameter int RX_START_CYCLES = RX_START_CYC,
    parameter int FAST_CYCLES = FAST_CYC,
    parameter int DET_BASE_CYCLES = DET_BASE_CYC,
    parameter int DET_STEP_CYCLES = DET_STEP_CYC
) (
    // clocking
    input wire logic clock_i,
    input wire logic clk_en_i,
    input wire logic sys_rst_i,
    // device pins
    input wire logic power_down_pin_i,
    output logic data_o,
    // deserialised register port
    input wire rpsp_pkg::rpsp_req_type req_i,
    output logic [7:0] rdata_o,
    output logic rdata_valid_o,
    // receiver side
    input wire logic rx_data_i,
    input wire logic preamble_match_i,
    output logic receiver_on_o,
    output logic crystal_on_o,
    output logic [3:0] power_state_o
);
    import rpsp_pkg::*;

    localparam int CW = 32;

    rpsp_state_type state_q, state_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [7:0] ctrl_q;
    logic [7:0] det_q;
    logic [7:0] ratio_q;
    logic preamb_q;
    logic hit_q;
    logic [CW-1:0] pd_cnt_q;
    logic pd_q;

    // decode, used for every address compare except the cfg_sel range check
    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        return a == b;
    endfunction

    rpsp_ctrl_type ctrl;
    wire alive = (state_q != ST_SHUTDOWN) && (state_q != ST_POWERUP);
    wire rx_active = (state_q == ST_HOST_RX) || (state_q == ST_POLL_RX);
    wire wr_ok = req_i.wr && alive;
    wire rd_ok = req_i.rd && alive;
    wire cfg_sel = req_i.addr < (ADDR_RXCFG_FIRST + 8'(RXCFG_WORDS));
    wire cfg_wr = wr_ok && cfg_sel && !rx_active;
    wire ctrl_wr = wr_ok && hit(req_i.addr, ADDR_STATE_CTRL);
    wire stat_rd = rd_ok && hit(req_i.addr, ADDR_INT_STATUS);
    wire [7:0] cfg_rdata;
    assign ctrl = rpsp_ctrl_type'({ctrl_q[CTRL_HRX_BIT], ctrl_q[CTRL_WUT_BIT], ctrl_q[CTRL_XO_BIT]});

    // detection and wait lengths in cycles
    wire [CW-1:0] det_cyc = CW'(DET_BASE_CYCLES) + CW'(det_q) * CW'(DET_STEP_CYCLES);
    wire [CW-1:0] ratio_n = CW'(ratio_q[RATIO_WIDTH-1:0]) + CW'(1);
    wire [CW-1:0] wait_cyc = det_cyc * ratio_n;
    wire cnt_done = (cnt_q == '0);

    // power-down filter: held high long enough forces shutdown
    wire pd_shut = pd_q;

    rpsp_cfg_mem #(.WORDS(RXCFG_WORDS), .AW(4)) u_cfg (
        .clock_i(clock_i),
        .clk_en_i(clk_en_i),
        .sys_rst_i(sys_rst_i || !alive),
        .wr_i(cfg_wr),
        .addr_i(req_i.addr[3:0]),
        .wdata_i(req_i.wdata),
        .rdata_o(cfg_rdata)
    );

    // power-down pin timing; any state reaches shutdown within the bound
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            pd_cnt_q <= '0;
            pd_q <= 1'b1;
        end else if (clk_en_i) begin
            if (!power_down_pin_i) begin
                pd_cnt_q <= '0;
                pd_q <= 1'b0;
            end else if (pd_cnt_q >= CW'(SHUTDOWN_CYCLES - 1)) begin
                pd_q <= 1'b1;
            end else begin
                pd_cnt_q <= pd_cnt_q + CW'(1);
            end
        end
    end

    // state sequencing
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_done ? cnt_q : cnt_q - CW'(1);
        unique case (state_q)
            ST_SHUTDOWN: begin
                if (!power_down_pin_i) begin
                    state_d = ST_POWERUP;
                    cnt_d = CW'(TURN_ON_CYCLES - 1);
                end
            end
            ST_POWERUP: begin
                if (cnt_done) begin
                    state_d = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (ctrl.crystal_enable) begin
                    state_d = ST_XO_START;
                    cnt_d = CW'(XO_START_CYCLES - 1);
                end
            end
            ST_XO_START: begin
                if (!ctrl.crystal_enable) begin
                    state_d = ST_SLEEP;
                end else if (cnt_done) begin
                    state_d = ST_STANDBY;
                end
            end
            ST_STANDBY: begin
                if (!ctrl.crystal_enable) begin
                    state_d = ST_SLEEP;
                end else if (ctrl.wake_timer_enable) begin
                    state_d = ST_WAIT;
                    cnt_d = CW'(FAST_CYCLES - 1);
                end else if (ctrl.host_rx_enable) begin
                    state_d = ST_RX_START;
                    cnt_d = CW'(RX_START_CYCLES - 1);
                end
            end
            ST_RX_START: begin
                if (!ctrl.host_rx_enable) begin
                    state_d = ST_STANDBY;
                end else if (cnt_done) begin
                    state_d = ST_HOST_RX;
                end
            end
            ST_HOST_RX: begin
                if (!ctrl.host_rx_enable) begin
                    state_d = ST_STANDBY;
                end
            end
            ST_POLL_RX: begin
                if (!ctrl.wake_timer_enable) begin
                    state_d = ST_STANDBY;
                end else if (cnt_done) begin
                    state_d = ST_WAIT;
                    cnt_d = wait_cyc - CW'(1);
                end
            end
            ST_WAIT: begin
                if (!ctrl.wake_timer_enable) begin
                    state_d = ST_STANDBY;
                end else if (cnt_done) begin
                    state_d = ST_POLL_RX;
                    cnt_d = det_cyc - CW'(1);
                end
            end
            default: begin
                state_d = ST_SHUTDOWN;
            end
        endcase
        // startup of the rx chain is not counted in the wait entry
        if (pd_shut) begin
            state_d = ST_SHUTDOWN;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_q <= ST_SHUTDOWN;
            cnt_q <= '0;
        end else if (clk_en_i) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // registers; lost in shutdown and defaulted on power-up
    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !alive) begin
            ctrl_q <= CTRL_RESET;
            det_q <= DET_TIME_RESET;
            ratio_q <= WAIT_RATIO_RESET;
            preamb_q <= 1'b0;
        end else if (clk_en_i) begin
            if (ctrl_wr) begin
                ctrl_q <= req_i.wdata;
            end
            if (wr_ok && !rx_active && hit(req_i.addr, ADDR_DET_TIME)) begin
                det_q <= req_i.wdata;
            end
            if (wr_ok && !rx_active && hit(req_i.addr, ADDR_WAIT_RATIO)) begin
                ratio_q <= {1'b0, req_i.wdata[RATIO_WIDTH-1:0]};
            end
            if (stat_rd && !ctrl_wr) begin
                ctrl_q[CTRL_WUT_BIT] <= 1'b0;
            end
            // a new match in the read cycle survives the clear
            if (state_q == ST_POLL_RX && preamble_match_i) begin
                preamb_q <= 1'b1;
            end else if (stat_rd) begin
                preamb_q <= 1'b0;
            end
        end
    end

    // read data and pin outputs, all registered
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            rdata_o <= 8'h00;
            rdata_valid_o <= 1'b0;
            data_o <= 1'b1;
            receiver_on_o <= 1'b0;
            crystal_on_o <= 1'b0;
            power_state_o <= 4'h0;
            hit_q <= 1'b0;
        end else if (clk_en_i) begin
            rdata_valid_o <= rd_ok;
            hit_q <= rd_ok && cfg_sel;
            if (hit(req_i.addr, ADDR_INT_STATUS)) begin
                rdata_o <= {7'h00, preamb_q};
            end else if (hit(req_i.addr, ADDR_STATE_CTRL)) begin
                rdata_o <= ctrl_q;
            end else if (hit(req_i.addr, ADDR_DET_TIME)) begin
                rdata_o <= det_q;
            end else if (hit(req_i.addr, ADDR_WAIT_RATIO)) begin
                rdata_o <= ratio_q;
            end else begin
                rdata_o <= 8'h00;
            end
            // data pin: follows rx data in host receive, otherwise low only in wait with a pending detection
            unique case (state_d)
                ST_HOST_RX: data_o <= rx_data_i;
                ST_WAIT: data_o <= !(preamb_q && state_q == ST_POLL_RX) && data_o;
                default: data_o <= 1'b1;
            endcase
            if (state_d == ST_WAIT && state_q == ST_WAIT) begin
                data_o <= !preamb_q || data_o ? (preamb_q ? data_o : 1'b1) : 1'b0;
            end
            receiver_on_o <= (state_d == ST_HOST_RX) || (state_d == ST_POLL_RX);
            crystal_on_o <= (state_d != ST_SHUTDOWN) && (state_d != ST_POWERUP) && (state_d != ST_SLEEP)
                            && (state_d != ST_XO_START);
            power_state_o <= state_d;
        end
    end
endmodule // rpsp_power_ctrl
`default_nettype wire

// ==== rpsp_power_ctrl_sva.sv ====
`default_nettype none
module rpsp_power_ctrl_sva
    import rpsp_pkg::*;
#(
    parameter int SHUTDOWN_CYCLES = 4,
    parameter int TURN_ON_CYCLES = 8,
    parameter int RX_START_CYCLES = 5,
    parameter int FAST_CYCLES = 3
) (
    // clocking
    input wire logic clock_i,
    input wire logic sys_rst_i,
    // pins and register port
    input wire logic power_down_pin_i,
    input wire logic data_o,
    input wire rpsp_pkg::rpsp_req_type req_i,
    input wire logic rdata_valid_o,
    // state outputs
    input wire logic receiver_on_o,
    input wire logic crystal_on_o,
    input wire logic [3:0] power_state_o
);
    // small slack on every bound, the counts are typical times
    localparam int SD_MAX = SHUTDOWN_CYCLES + 2;
    localparam int ON_MAX = TURN_ON_CYCLES + 2;
    localparam int RX_MAX = RX_START_CYCLES + 2;
    localparam int FAST_MAX = FAST_CYCLES + 2;
    // decoded host accesses and the polling-state flag
    wire logic ctrl_wr = req_i.wr && req_i.addr == ADDR_STATE_CTRL;
    wire logic stat_rd = req_i.rd && req_i.addr == ADDR_INT_STATUS;
    wire logic in_poll = power_state_o == ST_POLL_RX || power_state_o == ST_WAIT;
    default clocking @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);
    a_shutdown_entry: assert property ($rose(power_down_pin_i) |-> ##[1:SD_MAX] power_state_o == ST_SHUTDOWN)
        else $error("no shutdown after power-down");
    a_shutdown_deaf: assert property (power_state_o == ST_SHUTDOWN && req_i.rd |=> !rdata_valid_o)
        else $error("read answered in shutdown");
    a_sleep_entry: assert property ($fell(power_down_pin_i) |-> ##[1:ON_MAX] power_state_o == ST_SLEEP)
        else $error("no sleep after power-up");
    a_read_answer: assert property (req_i.rd && power_state_o inside {ST_STANDBY, ST_HOST_RX} |=> rdata_valid_o)
        else $error("read not answered");
    a_rx_start: assert property (power_state_o == ST_STANDBY && ctrl_wr && req_i.wdata[CTRL_HRX_BIT]
        && !req_i.wdata[CTRL_WUT_BIT] |-> ##[1:RX_MAX] receiver_on_o)
        else $error("receiver did not start");
    a_rx_stop: assert property (power_state_o == ST_HOST_RX && ctrl_wr && !req_i.wdata[CTRL_HRX_BIT]
        |-> ##[1:FAST_MAX] power_state_o == ST_STANDBY)
        else $error("host receive not left");
    a_standby_pins: assert property (power_state_o == ST_STANDBY |-> crystal_on_o && !receiver_on_o)
        else $error("standby outputs wrong");
    a_poll_high: assert property (power_state_o == ST_POLL_RX |-> data_o)
        else $error("data low in polling");
    a_status_exit: assert property (in_poll && stat_rd |-> ##[1:FAST_MAX] power_state_o == ST_STANDBY && data_o)
        else $error("status read did not end polling");
    // main scenarios reached
    c_host_rx: cover property (power_state_o == ST_HOST_RX);
    c_wait: cover property (power_state_o == ST_WAIT && !data_o);
    c_exit: cover property (in_poll && stat_rd);
endmodule // rpsp_power_ctrl_sva
bind rpsp_power_ctrl rpsp_power_ctrl_sva #(.SHUTDOWN_CYCLES(SHUTDOWN_CYCLES), .TURN_ON_CYCLES(TURN_ON_CYCLES),
    .RX_START_CYCLES(RX_START_CYCLES), .FAST_CYCLES(FAST_CYCLES)) rpsp_power_ctrl_sva_inst (.clock_i, .sys_rst_i,
    .power_down_pin_i, .data_o, .req_i, .rdata_valid_o, .receiver_on_o, .crystal_on_o, .power_state_o);
`default_nettype wire

// ==== rpsp_host_model.sv ====
`default_nettype none
module rpsp_host_model
    import rpsp_pkg::*;
#(
    parameter int HOLD_CYCLES = 20,
    parameter int TURN_ON_CYCLES = 8
) (
    input wire logic clock_i,
    input wire logic [7:0] rdata_i,
    input wire logic rdata_valid_i,
    output var rpsp_pkg::rpsp_req_type req_o,
    output var logic power_down_pin_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        req_o = '0;
        power_down_pin_o = 1'b1;
    end
    // one access, one edge wide; answer sampled after it settles
    task automatic access(input logic wr, input logic [7:0] addr, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clock_i);
        req_o <= '{wr: wr, rd: !wr, addr: addr, wdata: wd};
        @(posedge clock_i);
        req_o <= '0;
        // answer stands for one cycle: take it at the next edge, before it drops
        @(posedge clock_i);
        rd = rdata_valid_i ? rdata_i : 8'hXX;
    endtask
    task automatic set_pd(input logic v);
        @(posedge clock_i);
        power_down_pin_o <= v;
    endtask
    // scaled hold and turn-on wait; the host programs only after both
    task automatic power_cycle();
        set_pd(1'b1);
        repeat (HOLD_CYCLES) @(posedge clock_i);
        set_pd(1'b0);
        repeat (TURN_ON_CYCLES + 4) @(posedge clock_i);
        #1;
    endtask
endmodule // rpsp_host_model
`default_nettype wire

// ==== rpsp_power_ctrl_tb.sv ====
`default_nettype none
module rpsp_power_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import rpsp_pkg::*;
    localparam int SD = 4, TO = 8, DB = 4, DS = 2;
    logic clock_i, sys_rst_i, pd, rx_data, pmatch, valid, rx_on, xo_on, data;
    logic [7:0] rdata, d;
    logic [3:0] st;
    rpsp_req_type req;
    int num_errors = 0, n_checks = 0, n;
    rpsp_power_ctrl #(.SHUTDOWN_CYCLES(SD), .TURN_ON_CYCLES(TO), .XO_START_CYCLES(6), .RX_START_CYCLES(5),
        .FAST_CYCLES(3), .DET_BASE_CYCLES(DB), .DET_STEP_CYCLES(DS)) rpsp_power_ctrl_inst (.clock_i(clock_i),
        .clk_en_i(1'b1), .sys_rst_i(sys_rst_i), .power_down_pin_i(pd), .data_o(data), .req_i(req),
        .rdata_o(rdata), .rdata_valid_o(valid), .rx_data_i(rx_data), .preamble_match_i(pmatch),
        .receiver_on_o(rx_on), .crystal_on_o(xo_on), .power_state_o(st));
    rpsp_host_model #(.TURN_ON_CYCLES(TO)) rpsp_host_model_inst (.clock_i(clock_i), .rdata_i(rdata),
        .rdata_valid_i(valid), .req_o(req), .power_down_pin_o(pd));
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        rpsp_host_model_inst.access(1'b1, a, v, d);
    endtask
    task automatic rd(input logic [7:0] a);
        rpsp_host_model_inst.access(1'b0, a, 8'h00, d);
    endtask
    // bounded wait for a state, then dwell length in a state
    task automatic wait_st(input logic [3:0] s);
        n = 0;
        while (st !== s && n < 200) begin
            @(posedge clock_i);
            #1;
            n++;
        end
    endtask
    task automatic dwell(input logic [3:0] s);
        n = 0;
        while (st === s && n < 500) begin
            @(posedge clock_i);
            #1;
            n++;
        end
    endtask
    task automatic t_powerup();
        rpsp_host_model_inst.power_cycle();
        chk("sleep", 8'(ST_SLEEP), 8'(st));
        rd(ADDR_STATE_CTRL);
        chk("ctrl default", CTRL_RESET, d);
        rd(ADDR_DET_TIME);
        chk("det default", DET_TIME_RESET, d);
        wr(ADDR_STATE_CTRL, 8'h01);
        wait_st(ST_STANDBY);
        chk("xo running", 8'h01, 8'(xo_on));
        $display("t_powerup done");
    endtask
    task automatic t_host_rx();
        wr(ADDR_DET_TIME, 8'h01);
        wr(ADDR_STATE_CTRL, 8'h05);
        wait_st(ST_HOST_RX);
        chk("receiver on", 8'h01, 8'(rx_on));
        rx_data <= 1'b0;
        wr(ADDR_DET_TIME, 8'hAA);
        rd(ADDR_DET_TIME);
        chk("config locked", 8'h01, d);
        chk("data follows rx", 8'h00, 8'(data));
        rx_data <= 1'b1;
        wr(ADDR_STATE_CTRL, 8'h01);
        wait_st(ST_STANDBY);
        chk("rx off", 8'h00, 8'(rx_on));
        $display("t_host_rx done");
    endtask
    // code 1 and ratio field 1: detect 6 cycles, wait 12
    task automatic t_poll();
        wr(ADDR_WAIT_RATIO, 8'h01);
        wr(ADDR_STATE_CTRL, 8'h03);
        wait_st(ST_POLL_RX);
        dwell(ST_POLL_RX);
        dwell(ST_WAIT);
        chk("wait len", 8'(2 * (DB + DS)), 8'(n));
        dwell(ST_POLL_RX);
        chk("detect len", 8'(DB + DS), 8'(n));
        chk("idle wait data", 8'h01, 8'(data));
        wait_st(ST_POLL_RX);
        pmatch <= 1'b1;
        @(posedge clock_i);
        pmatch <= 1'b0;
        dwell(ST_POLL_RX);
        chk("data fell", 8'h00, 8'(data));
        dwell(ST_WAIT);
        chk("repoll data", 8'h01, 8'(data));
        dwell(ST_POLL_RX);
        chk("data fell again", 8'h00, 8'(data));
        rd(ADDR_INT_STATUS);
        chk("flag", 8'h01, d & 8'h01);
        wait_st(ST_STANDBY);
        chk("data released", 8'h01, 8'(data));
        rd(ADDR_STATE_CTRL);
        chk("timer cleared", 8'h01, d);
        wr(ADDR_STATE_CTRL, 8'h05);
        wait_st(ST_HOST_RX);
        chk("rx after wake", 8'h01, 8'(rx_on));
        wr(ADDR_STATE_CTRL, 8'h01);
        wait_st(ST_STANDBY);
        $display("t_poll done");
    endtask
    task automatic t_shutdown();
        rpsp_host_model_inst.set_pd(1'b1);
        wait_st(ST_SHUTDOWN);
        chk("shutdown time", 8'h01, 8'(n <= SD + 2));
        rpsp_host_model_inst.power_cycle();
        rd(ADDR_STATE_CTRL);
        chk("ctrl lost", CTRL_RESET, d);
        $display("t_shutdown done");
    endtask
    task automatic end_sim();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        sys_rst_i = 1'b1;
        rx_data = 1'b1;
        pmatch = 1'b0;
        repeat (8) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        t_powerup();
        t_host_rx();
        t_poll();
        t_shutdown();
        end_sim();
    end
    // whole run is a few hundred cycles
    initial begin
        #100000;
        num_errors++;
        $display("watchdog expired");
        end_sim();
    end
endmodule // rpsp_power_ctrl_tb
`default_nettype wire
